// ==== kps_defines.svh ====
`ifndef KPS_DEFINES_SVH
`define KPS_DEFINES_SVH
`define KPS_CLK_MHZ 250
`define KPS_KEY_FILT_US 16000
`define KPS_KEY_FILT_CYC (`KPS_KEY_FILT_US * `KPS_CLK_MHZ)
`define KPS_REG_DLY_US 100
`define KPS_REG_DLY_CYC (`KPS_REG_DLY_US * `KPS_CLK_MHZ)
`define KPS_V3_DLY_US 1000
`define KPS_V3_DLY_CYC (`KPS_V3_DLY_US * `KPS_CLK_MHZ)
`define KPS_OV_FILT_US 50
`define KPS_OV_FILT_CYC (`KPS_OV_FILT_US * `KPS_CLK_MHZ)
`endif

// ==== kps_pkg.sv ====
package kps_pkg;
  typedef enum logic [2:0] {
    KPS_OFF = 3'b000,
    KPS_RELAY = 3'b001,
    KPS_BIAS = 3'b010,
    KPS_RAIL5 = 3'b011,
    KPS_RAIL3 = 3'b100,
    KPS_ON = 3'b101,
    KPS_DUMP = 3'b110
  } kps_state_t;
  typedef struct packed {
    logic main_relay_drive;
    logic bias_en;
    logic five_volt_en;
    logic tracking_supply_one_en;
    logic tracking_supply_two_en;
    logic three_volt_en;
  } kps_en_t;
  typedef struct packed {
    logic battery_uv_release;
    logic five_volt_uv_ok;
    logic battery_ov;
  } kps_cmp_t;
endpackage

// ==== kps_sequencer.sv ====
`timescale 1ns/1ps
`include "kps_defines.svh"
module kps_sequencer
  import kps_pkg::*;
#(
  parameter int unsigned KEY_FILT_CYC = `KPS_KEY_FILT_CYC,
  parameter int unsigned REG_DLY_CYC = `KPS_REG_DLY_CYC,
  parameter int unsigned V3_DLY_CYC = `KPS_V3_DLY_CYC,
  parameter int unsigned OV_FILT_CYC = `KPS_OV_FILT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // key pin and strap
  input wire logic key_high_threshold,
  input wire logic permanent_supply,
  // analog comparators
  input wire kps_cmp_t cmp,
  // supply enables, filtered key and dump flag
  output kps_en_t en,
  output logic key_filtered,
  output logic dump_off
);
  // ---------------------------------------------------------------
  // shared arithmetic
  // ---------------------------------------------------------------
  function automatic logic [31:0] inc32(input logic [31:0] v);
    return v + 32'h0000_0001;
  endfunction

  // ---------------------------------------------------------------
  // key deglitch filter
  // ---------------------------------------------------------------
  logic [31:0] key_cnt_ff;
  logic [31:0] nxt_key_cnt;
  logic key_filt_ff;
  logic nxt_key_filt;
  wire key_settle = (key_cnt_ff >= KEY_FILT_CYC - 1);
  assign nxt_key_cnt = (key_high_threshold != key_filt_ff) ?
                       (key_settle ? 32'h0000_0000 : inc32(key_cnt_ff)) :
                       32'h0000_0000;
  assign nxt_key_filt = (key_high_threshold != key_filt_ff && key_settle) ?
                        key_high_threshold : key_filt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_cnt_ff <= 32'h0000_0000;
      key_filt_ff <= 1'b0;
    end else begin
      key_cnt_ff <= nxt_key_cnt;
      key_filt_ff <= nxt_key_filt;
    end
  end
  assign key_filtered = key_filt_ff;

  // ---------------------------------------------------------------
  // overvoltage filter
  // ---------------------------------------------------------------
  logic [31:0] ov_cnt_ff;
  logic [31:0] nxt_ov_cnt;
  wire ov_trip = cmp.battery_ov && (ov_cnt_ff >= OV_FILT_CYC);
  assign nxt_ov_cnt = !cmp.battery_ov ? 32'h0000_0000 :
                      (ov_trip ? ov_cnt_ff : inc32(ov_cnt_ff));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ov_cnt_ff <= 32'h0000_0000;
    end else begin
      ov_cnt_ff <= nxt_ov_cnt;
    end
  end

  // ---------------------------------------------------------------
  // sequence state machine
  // ---------------------------------------------------------------
  kps_state_t state_ff;
  kps_state_t nxt_state;
  logic [31:0] dly_ff;
  logic [31:0] nxt_dly;
  wire reg_due = (dly_ff >= REG_DLY_CYC - 1);
  wire v3_due = (dly_ff >= V3_DLY_CYC - 1);
  // permanent supply: the key filter already expired when leaving off
  always_comb begin
    nxt_state = state_ff;
    nxt_dly = 32'h0000_0000;
    case (state_ff)
      KPS_OFF: begin
        if (key_filt_ff) begin
          nxt_state = permanent_supply ? KPS_BIAS : KPS_RELAY;
        end
      end
      KPS_RELAY: begin
        if (cmp.battery_uv_release) begin
          nxt_state = KPS_BIAS;
        end
      end
      KPS_BIAS: begin
        nxt_dly = inc32(dly_ff);
        if (reg_due) begin
          nxt_state = KPS_RAIL5;
          nxt_dly = 32'h0000_0000;
        end
      end
      KPS_RAIL5: begin
        if (cmp.five_volt_uv_ok) begin
          nxt_state = KPS_RAIL3;
        end
      end
      KPS_RAIL3: begin
        nxt_dly = inc32(dly_ff);
        if (!cmp.five_volt_uv_ok) begin
          nxt_dly = 32'h0000_0000;
        end else if (v3_due) begin
          nxt_state = KPS_ON;
          nxt_dly = 32'h0000_0000;
        end
      end
      KPS_ON: begin
        nxt_state = KPS_ON;
      end
      KPS_DUMP: begin
        if (!key_filt_ff && !cmp.battery_ov) begin
          nxt_state = KPS_OFF;
        end
      end
      default: begin
        nxt_state = KPS_OFF;
      end
    endcase
    if (ov_trip && state_ff != KPS_OFF) begin
      nxt_state = KPS_DUMP;
      nxt_dly = 32'h0000_0000;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= KPS_OFF;
      dly_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      dly_ff <= nxt_dly;
    end
  end

  // ---------------------------------------------------------------
  // registered enables
  // ---------------------------------------------------------------
  kps_en_t en_ff;
  kps_en_t nxt_en;
  wire up = (nxt_state != KPS_OFF) && (nxt_state != KPS_DUMP);
  wire rail5 = (nxt_state == KPS_RAIL5) || (nxt_state == KPS_RAIL3) ||
               (nxt_state == KPS_ON);
  assign nxt_en.main_relay_drive = up;
  assign nxt_en.bias_en = up && (nxt_state != KPS_RELAY);
  assign nxt_en.five_volt_en = rail5;
  assign nxt_en.tracking_supply_one_en = rail5;
  assign nxt_en.tracking_supply_two_en = rail5;
  assign nxt_en.three_volt_en = (nxt_state == KPS_ON);
  logic dump_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_ff <= '0;
      dump_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
      dump_ff <= (nxt_state == KPS_DUMP);
    end
  end
  assign en = en_ff;
  assign dump_off = dump_ff;

  // ---------------------------------------------------------------
  // bias to five volt counter
  // ---------------------------------------------------------------
  logic [31:0] bias_wait_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bias_wait_ff <= 32'h0000_0000;
    end else if (en.bias_en && !en.five_volt_en) begin
      bias_wait_ff <= inc32(bias_wait_ff);
    end else begin
      bias_wait_ff <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_relay_needs_key: assert property (
    $rose(en.main_relay_drive) |-> $past(key_filt_ff))
    else $error("relay enabled without filtered key");
  a_key_filter_hold: assert property (
    $rose(key_filt_ff) |-> $past(key_cnt_ff) == KEY_FILT_CYC - 1)
    else $error("key filter released early");
  a_relay_first: assert property (
    $rose(en.main_relay_drive) && !permanent_supply |-> !en.bias_en)
    else $error("bias came with relay");
  a_bias_uv_gate: assert property (
    $rose(en.bias_en) && !permanent_supply |-> $past(cmp.battery_uv_release))
    else $error("bias without battery release");
  a_five_delay: assert property (
    $rose(en.five_volt_en) |-> $past(dly_ff) == REG_DLY_CYC - 1)
    else $error("five volt delay wrong");
  a_three_delay: assert property (
    $rose(en.three_volt_en) |-> $past(dly_ff) == V3_DLY_CYC - 1 && cmp.five_volt_uv_ok)
    else $error("three volt delay wrong");
  a_track_together: assert property (
    en.five_volt_en == en.tracking_supply_one_en &&
    en.five_volt_en == en.tracking_supply_two_en)
    else $error("tracking supplies not with five volt");
  a_perm_bias: assert property (
    $rose(en.main_relay_drive) && permanent_supply |-> en.bias_en)
    else $error("permanent bias late");
  a_perm_five: assert property (
    $rose(en.five_volt_en) && permanent_supply |-> bias_wait_ff == REG_DLY_CYC)
    else $error("permanent five volt delay wrong");
  a_dump_off: assert property (
    ov_trip && state_ff != KPS_OFF |=> en == '0)
    else $error("no shutdown on overvoltage");
  a_ov_filter: assert property (
    $rose(dump_off) |-> $past(ov_cnt_ff) == OV_FILT_CYC)
    else $error("overvoltage filter too short");
  a_five_after_bias: assert property (
    $rose(en.five_volt_en) |-> en.bias_en && en.main_relay_drive)
    else $error("five volt without bias");
  c_turn_on: cover property ($rose(en.three_volt_en));
  c_perm_on: cover property ($rose(en.five_volt_en) && permanent_supply);
  c_dump: cover property ($rose(dump_off));
  c_relay_bias: cover property ($rose(en.bias_en) && !permanent_supply);
  c_dump_exit: cover property ($fell(dump_off));
endmodule

// ==== kps_analog_model.sv ====
`timescale 1ns/1ps
module kps_analog_model
  import kps_pkg::*;
(
  // clock, reset and strap
  input wire logic clk,
  input wire logic rstn,
  input wire logic permanent_supply,
  // overvoltage request and enables
  input wire logic ov_req,
  input wire kps_en_t en,
  // comparator outputs
  output kps_cmp_t cmp
);
  logic [2:0] relay_ff;
  logic [1:0] five_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      relay_ff <= 3'h0;
      five_ff <= 2'h0;
    end else begin
      relay_ff <= {relay_ff[1:0], en.main_relay_drive};
      five_ff <= {five_ff[0], en.five_volt_en};
    end
  end
  // battery rail rises late behind the relay
  assign cmp.battery_uv_release = permanent_supply | relay_ff[2];
  assign cmp.five_volt_uv_ok = five_ff[1];
  assign cmp.battery_ov = ov_req;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb
  import kps_pkg::*;
();
  localparam int KF = 8;
  localparam int RD = 4;
  localparam int VD = 6;
  localparam int OF = 3;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic key = 1'b0;
  logic perm = 1'b0;
  logic ov = 1'b0;
  kps_cmp_t cmp;
  kps_en_t en;
  logic kf;
  logic dump;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  wire [8:0] obs = {cmp.five_volt_uv_ok, en, kf, dump};
  always #2 clk = ~clk;
  kps_sequencer #(.KEY_FILT_CYC(KF), .REG_DLY_CYC(RD), .V3_DLY_CYC(VD), .OV_FILT_CYC(OF))
    kps_sequencer_inst (.clk(clk), .rstn(rstn), .key_high_threshold(key),
    .permanent_supply(perm), .cmp(cmp), .en(en), .key_filtered(kf), .dump_off(dump));
  kps_analog_model kps_analog_model_inst (.clk(clk), .rstn(rstn),
    .permanent_supply(perm), .ov_req(ov), .en(en), .cmp(cmp));
  task give_verdict();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wt(input int b, input logic v);
    n = 0;
    while (obs[b] !== v && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) begin
      chk(1'b0, "wait timed out");
      give_verdict();
    end
  endtask
  task do_reset(input logic p);
    @(posedge clk);
    rstn <= 1'b0;
    perm <= p;
    key <= 1'b0;
    ov <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    chk(en === '0 && kf === 1'b0 && dump === 1'b0, "outputs after reset");
  endtask
  task t_glitch();
    @(posedge clk) key <= 1'b1;
    repeat (KF - 2) @(posedge clk);
    key <= 1'b0;
    tick(KF + 4);
    chk(kf === 1'b0 && en === '0, "short key pulse turned on");
  endtask
  task t_relay_seq();
    @(posedge clk) key <= 1'b1;
    wt(1, 1'b1);
    wt(7, 1'b1);
    chk(en === 6'h20, "relay not first");
    wt(6, 1'b1);
    chk(cmp.battery_uv_release === 1'b1 && en === 6'h30, "bias early");
    wt(5, 1'b1);
    chk(n == RD, "five volt delay");
    chk({en.tracking_supply_one_en, en.tracking_supply_two_en} === 2'b11, "tracking");
    wt(8, 1'b1);
    chk(en.three_volt_en === 1'b0, "three volt early");
    wt(2, 1'b1);
    chk(n >= VD && n <= VD + 2, "three volt delay");
  endtask
  task t_dump();
    @(posedge clk) ov <= 1'b1;
    repeat (OF - 1) @(posedge clk);
    ov <= 1'b0;
    tick(3);
    chk(dump === 1'b0 && en === 6'h3f, "short overvoltage tripped");
    @(posedge clk) ov <= 1'b1;
    wt(0, 1'b1);
    chk(n <= OF + 3 && en === '0, "dump shutdown");
    @(posedge clk) ov <= 1'b0;
    key <= 1'b0;
    wt(0, 1'b0);
    chk(en === '0, "enables after dump");
  endtask
  task t_perm();
    do_reset(1'b1);
    @(posedge clk) key <= 1'b1;
    wt(1, 1'b1);
    wt(6, 1'b1);
    chk(n <= 1, "bias late with permanent battery");
    wt(5, 1'b1);
    chk(n == RD, "five volt delay permanent");
  endtask
  initial begin
    do_reset(1'b0);
    t_glitch();
    t_relay_seq();
    t_dump();
    t_perm();
    give_verdict();
  end
endmodule
